// ===== bench/pscoc_chk.sv
// port assertions for the pwm configuration slice
// assumes aligned apb word accesses at the offsets of pscoc_map.vh
`timescale 1ns/10ps
`default_nettype none
module pscoc_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic first_period_event,
   input wire logic second_period_event,
   input wire logic first_period_restart,
   input wire logic second_period_restart,
   input wire logic sys_clk_tick,
   input wire logic pll_clk_tick,
   input wire logic first_external_clock_pin,
   input wire logic first_clock_tick,
   input wire logic first_external_event_input,
   input wire logic first_event_active,
   input wire logic [5:0] first_wave,
   input wire logic [5:0] first_port_out,
   input wire logic [5:0] first_port_oe,
   input wire logic [5:0] first_pin_out,
   input wire logic [5:0] first_pin_oe
);
   logic [7:0] sh [0:7];
   logic [1:0] cs;
   logic sel1, sel2, tick1;
   logic [5:0] oe1, out1;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // shadow of the registers, stored at the same edge as the design
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 8; i++) sh[i] <= 8'h00;
      end else if (psel && penable && pwrite && paddr < 12'h020 && paddr[1:0] == 2'h0) begin
         sh[paddr[4:2]] <= pwdata[7:0];
      end
   end
   assign cs = sh[2][1:0];
   // expected outputs one cycle ahead; the properties compare them through $past
   assign sel1 = (sh[0][1:0] == 2'h2) ? second_period_event : first_period_event;
   assign sel2 = (sh[1][1:0] == 2'h1) ? first_period_event : second_period_event;
   assign tick1 = (cs == 2'h0) ? sys_clk_tick : (cs == 2'h1) ? pll_clk_tick :
      (cs == 2'h2) ? first_external_clock_pin : 1'b0;
   assign oe1 = sh[3][5:0] | first_port_oe;
   assign out1 = (sh[3][5:0] & (first_wave ^ sh[4][5:0])) | (~sh[3][5:0] & first_port_out);
   sequence rd_acc;
      psel && penable && !pwrite;
   endsequence
   sequence sec_rd;
      rd_acc ##0 (paddr == 12'h018 || paddr == 12'h01C);
   endsequence
   AST_SYNC1: assert property (first_period_restart == $past(sel1))
      else $error("first restart source wrong");
   AST_SYNC2: assert property (second_period_restart == $past(sel2))
      else $error("second restart source wrong");
   AST_SYNC_HI: assert property (rd_acc ##0 paddr < 12'h008 |-> prdata[7:2] == 6'h00)
      else $error("sync upper bits not zero");
   AST_SECOND_HI: assert property (sec_rd |-> prdata[5:2] == 4'h0)
      else $error("second instance c to f bits not zero");
   AST_CLK_SRC: assert property (first_clock_tick == $past(tick1))
      else $error("clock tick source wrong");
   AST_PIN_OE: assert property (first_pin_oe == $past(oe1))
      else $error("pin enable wrong");
   AST_PIN_OUT: assert property (first_pin_out == $past(out1))
      else $error("pin level wrong");
   AST_EVT_POL: assert property (first_event_active == $past(first_external_event_input ^ sh[4][6]))
      else $error("input polarity wrong");
endmodule // pscoc_chk
bind pscoc_top pscoc_chk i_pscoc_chk (.*);
`default_nettype wire

// ===== bench/pscoc_port_mdl.sv
// ordinary port logic that owns the pins while the pwm is not routed
// assumes pclk; the pattern moves every cycle so a stale pin shows
`timescale 1ns/10ps
`default_nettype none
module pscoc_port_mdl (
   input wire logic pclk,
   input wire logic presetn,
   output logic [5:0] first_port_out,
   output logic [5:0] first_port_oe,
   output logic [1:0] second_port_out,
   output logic [1:0] second_port_oe
);
   logic [7:0] cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 8'h00;
      end else begin
         cnt <= cnt + 8'h25;
      end
   end
   assign first_port_out = cnt[5:0];
   assign first_port_oe = cnt[7:2];
   assign second_port_out = cnt[1:0];
   assign second_port_oe = ~cnt[3:2];
endmodule // pscoc_port_mdl
`default_nettype wire

// ===== bench/pscoc_top_tb.sv
// self-checking bench of the pwm configuration slice
// assumes pscoc_top, the port logic model and the bound checker
`timescale 1ns/10ps
`default_nettype none
`include "pscoc_map.vh"
module pscoc_top_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic first_period_event, second_period_event, sys_clk_tick, pll_clk_tick;
   logic first_external_clock_pin, second_external_clock_pin;
   logic first_external_event_input, second_external_event_input;
   logic [5:0] first_wave, first_port_out, first_port_oe, first_pin_out, first_pin_oe;
   logic [1:0] second_wave, second_port_out, second_port_oe, second_pin_out, second_pin_oe;
   logic first_period_restart, second_period_restart, first_clock_tick, second_clock_tick;
   logic [1:0] first_clock_prescale_sel, second_clock_prescale_sel;
   logic first_event_active, second_event_active;
   int err_count, cmp_count, cyc_n;
   pscoc_top i_pscoc_top (.*);
   pscoc_port_mdl i_pscoc_port_mdl (.*);
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc_n++;
      if (cyc_n == 3000) begin
         err_count++;
         wrap_up;
      end
   end
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic t_regs;
      logic [7:0] wv [8] = '{8'hFE, 8'hFD, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
      logic [7:0] ex [8] = '{8'h02, 8'h01, 8'h33, 8'h3F, 8'h7F, 8'h33, 8'h03, 8'h43};
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0);
         chk("reset value", 32'h0, r);
         apb(1'b1, 12'(i * 4), {24'hFFFFFF, wv[i]});
         apb(1'b0, 12'(i * 4), 32'h0);
         chk("read back", {24'h0, ex[i]}, r);
         apb(1'b1, 12'(i * 4), 32'h0);
      end
      apb(1'b1, 12'h020, 32'hFF);
      chk("unmapped error", 32'h1, {31'h0, e});
      $display("register test done");
   endtask
   task automatic pulse(input logic [1:0] ev, input logic [1:0] ex);
      @(posedge pclk);
      {second_period_event, first_period_event} <= ev;
      @(posedge pclk);
      {second_period_event, first_period_event} <= 2'h0;
      #1 chk("restart", {30'h0, ex}, {30'h0, second_period_restart, first_period_restart});
   endtask
   task automatic t_sync;
      pulse(2'h1, 2'h1);
      pulse(2'h2, 2'h2);
      apb(1'b1, `PSCOC_OFF_SYNC1, 32'h2);
      pulse(2'h2, 2'h3);
      pulse(2'h1, 2'h0);
      apb(1'b1, `PSCOC_OFF_SYNC2, 32'h1);
      pulse(2'h1, 2'h2);
      pulse(2'h2, 2'h1);
      $display("sync test done");
   endtask
   task automatic t_clk;
      logic [1:0] c;
      for (int k = 0; k < 4; k++) begin
         c = 2'(k);
         apb(1'b1, `PSCOC_OFF_CLK1, {26'h0, c, 2'h0, c});
         #1 chk("prescale", {30'h0, c}, {30'h0, first_clock_prescale_sel});
         apb(1'b1, `PSCOC_OFF_CLK2, {26'h0, c, 4'h0});
         #1 chk("prescale2", {30'h0, c}, {30'h0, second_clock_prescale_sel});
         for (int s = 0; s < 3; s++) begin
            @(posedge pclk);
            {first_external_clock_pin, pll_clk_tick, sys_clk_tick} <= 3'(1 << s);
            second_external_clock_pin <= (s == 2);
            @(posedge pclk);
            {first_external_clock_pin, pll_clk_tick, sys_clk_tick} <= 3'h0;
            second_external_clock_pin <= 1'b0;
            #1 chk("first tick", {31'h0, k == s}, {31'h0, first_clock_tick});
            chk("second tick", {31'h0, s == 0}, {31'h0, second_clock_tick});
         end
      end
      $display("clock test done");
   endtask
   task automatic t_pins;
      logic [5:0] o1, oe1;
      logic [1:0] o2, oe2;
      apb(1'b1, `PSCOC_OFF_OEN1, 32'h15);
      apb(1'b1, `PSCOC_OFF_POL1, 32'h4A);
      apb(1'b1, `PSCOC_OFF_OEN2, 32'h01);
      apb(1'b1, `PSCOC_OFF_POL2, 32'h42);
      for (int n = 0; n < 4; n++) begin
         @(posedge pclk);
         first_wave <= 6'(n * 13);
         second_wave <= 2'(n);
         {second_external_event_input, first_external_event_input} <= 2'(n);
         // port logic moves every edge; take what the design will sample at the next one
         #1 {o1, oe1, o2, oe2} = {first_port_out, first_port_oe, second_port_out, second_port_oe};
         @(posedge pclk);
         #1 chk("pin1", {26'h0, ((6'(n * 13) ^ 6'h0A) & 6'h15) | (o1 & 6'h2A)}, {26'h0, first_pin_out});
         chk("oe1", {26'h0, 6'h15 | oe1}, {26'h0, first_pin_oe});
         chk("pin2", {30'h0, ((2'(n) ^ 2'h2) & 2'h1) | (o2 & 2'h2)}, {30'h0, second_pin_out});
         chk("oe2", {30'h0, 2'h1 | oe2}, {30'h0, second_pin_oe});
         chk("events", {30'h0, ~2'(n)}, {30'h0, second_event_active, first_event_active});
      end
      $display("pin test done");
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {first_period_event, second_period_event, sys_clk_tick, pll_clk_tick} = '0;
      {first_external_clock_pin, second_external_clock_pin} = '0;
      {first_external_event_input, second_external_event_input} = '0;
      {first_wave, second_wave} = '0;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_sync;
      t_clk;
      t_pins;
      wrap_up;
   end
endmodule // pscoc_top_tb
`default_nettype wire

// ===== logic/pscoc_evt_sel.v
// per-instance period restart, clock source and input polarity selection
// assumes all tick and event inputs are one-cycle pulses synchronous to pclk
`timescale 1ns/10ps
`default_nettype none
`include "pscoc_map.vh"

module pscoc_evt_sel #(
   parameter [1:0] PEER_CODE = 2'h0
) (
   input wire pclk,
   input wire presetn,
   input wire [1:0] sync_mode,
   input wire [1:0] clock_source_sel,
   input wire input_polarity,
   input wire own_period_event,
   input wire peer_period_event,
   input wire sys_clk_tick,
   input wire pll_clk_tick,
   input wire external_clock_pin,
   input wire external_event_input,
   output reg period_restart,
   output reg clock_tick,
   output reg event_active
);
   reg next_restart;
   reg next_tick;

   // reserved sync codes fall back to free running so a bad write cannot stall the period
   always @* begin
      if (sync_mode == PEER_CODE) begin
         next_restart = peer_period_event;
      end else begin
         next_restart = own_period_event;
      end
   end

   always @* begin
      if (clock_source_sel == `PSCOC_CSRC_SYS) begin
         next_tick = sys_clk_tick;
      end else if (clock_source_sel == `PSCOC_CSRC_PLL) begin
         next_tick = pll_clk_tick;
      end else if (clock_source_sel == `PSCOC_CSRC_EXT) begin
         next_tick = external_clock_pin;
      end else begin
         next_tick = 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_restart <= 1'b0;
         clock_tick <= 1'b0;
         event_active <= 1'b0;
      end else begin
         period_restart <= next_restart;
         clock_tick <= next_tick;
         event_active <= external_event_input ^ input_polarity;
      end
   end
endmodule // pscoc_evt_sel

`default_nettype wire

// ===== logic/pscoc_map.vh
// constants of the pwm sync, clock, output and polarity configuration slice
// assumes an apb slave with 32-bit data, one aligned word per register
`ifndef PSCOC_MAP_VH
`define PSCOC_MAP_VH

`define PSCOC_OFF_SYNC1 12'h000
`define PSCOC_OFF_SYNC2 12'h004
`define PSCOC_OFF_CLK1 12'h008
`define PSCOC_OFF_OEN1 12'h00C
`define PSCOC_OFF_POL1 12'h010
`define PSCOC_OFF_CLK2 12'h014
`define PSCOC_OFF_OEN2 12'h018
`define PSCOC_OFF_POL2 12'h01C

`define PSCOC_RST_REG 8'h00

`define PSCOC_MASK_SYNC 8'h03
`define PSCOC_MASK_CLK 8'h33
`define PSCOC_MASK_OEN1 8'h3F
`define PSCOC_MASK_OEN2 8'h03
`define PSCOC_MASK_POL1 8'h7F
`define PSCOC_MASK_POL2 8'h43

`define PSCOC_SYNC_MSB 1
`define PSCOC_SYNC_LSB 0
`define PSCOC_CSRC_MSB 1
`define PSCOC_CSRC_LSB 0
`define PSCOC_CPRE_MSB 5
`define PSCOC_CPRE_LSB 4
`define PSCOC_POLIN_BIT 6

`define PSCOC_SYNC_OWN 2'h0
`define PSCOC_SYNC1_PEER 2'h2
`define PSCOC_SYNC2_PEER 2'h1

`define PSCOC_CSRC_SYS 2'h0
`define PSCOC_CSRC_PLL 2'h1
`define PSCOC_CSRC_EXT 2'h2

`define PSCOC_OUTS1 6
`define PSCOC_OUTS2 2

`endif

// ===== logic/pscoc_out_stage.v
// pin output stage: polarity, then hand-over between pwm and port logic
// assumes port_out and port_oe come from the ordinary port logic of each pin
`timescale 1ns/10ps
`default_nettype none
`include "pscoc_map.vh"

module pscoc_out_stage #(
   parameter W = 6
) (
   input wire pclk,
   input wire presetn,
   input wire [W-1:0] wave,
   input wire [W-1:0] output_route_en,
   input wire [W-1:0] output_polarity,
   input wire [W-1:0] port_out,
   input wire [W-1:0] port_oe,
   output reg [W-1:0] pin_out,
   output reg [W-1:0] pin_oe
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_pin
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_out[i] <= 1'b0;
               pin_oe[i] <= 1'b0;
            end else if (output_route_en[i]) begin
               pin_out[i] <= wave[i] ^ output_polarity[i];
               pin_oe[i] <= 1'b1;
            end else begin
               pin_out[i] <= port_out[i];
               pin_oe[i] <= port_oe[i];
            end
         end
      end
   endgenerate
endmodule // pscoc_out_stage

`default_nettype wire

// ===== logic/pscoc_top.v
// configuration slice of two pwm instances: apb registers, period sync,
// clock source, pin routing and polarity
// assumes a zero-wait apb master on pclk; all other inputs synchronous to pclk
`timescale 1ns/10ps
`default_nettype none
`include "pscoc_map.vh"

module pscoc_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   input wire first_period_event,
   input wire second_period_event,
   input wire sys_clk_tick,
   input wire pll_clk_tick,
   input wire first_external_clock_pin,
   input wire second_external_clock_pin,
   input wire first_external_event_input,
   input wire second_external_event_input,
   input wire [5:0] first_wave,
   input wire [1:0] second_wave,
   input wire [5:0] first_port_out,
   input wire [5:0] first_port_oe,
   input wire [1:0] second_port_out,
   input wire [1:0] second_port_oe,
   output wire first_period_restart,
   output wire second_period_restart,
   output wire first_clock_tick,
   output wire second_clock_tick,
   output wire [1:0] first_clock_prescale_sel,
   output wire [1:0] second_clock_prescale_sel,
   output wire first_event_active,
   output wire second_event_active,
   output wire [5:0] first_pin_out,
   output wire [5:0] first_pin_oe,
   output wire [1:0] second_pin_out,
   output wire [1:0] second_pin_oe
);
   reg [7:0] first_period_sync_select;
   reg [7:0] second_period_sync_select;
   reg [7:0] first_clock_select;
   reg [7:0] first_output_enables;
   reg [7:0] first_polarity_control;
   reg [7:0] second_clock_select;
   reg [7:0] second_output_enables;
   reg [7:0] second_polarity_control;

   reg [7:0] next_rdata;
   reg next_err;
   wire setup_phase;
   wire write_strobe;

   assign setup_phase = psel & ~penable;
   assign write_strobe = psel & penable & pwrite & ~pslverr;
   // every access completes in its first access cycle
   assign pready = 1'b1;

   // read mux and decode; unmapped offsets read zero and flag an error
   always @* begin
      next_rdata = 8'h00;
      next_err = 1'b0;
      if (paddr == `PSCOC_OFF_SYNC1) begin
         next_rdata = first_period_sync_select & `PSCOC_MASK_SYNC;
      end else if (paddr == `PSCOC_OFF_SYNC2) begin
         next_rdata = second_period_sync_select & `PSCOC_MASK_SYNC;
      end else if (paddr == `PSCOC_OFF_CLK1) begin
         next_rdata = first_clock_select & `PSCOC_MASK_CLK;
      end else if (paddr == `PSCOC_OFF_OEN1) begin
         next_rdata = first_output_enables & `PSCOC_MASK_OEN1;
      end else if (paddr == `PSCOC_OFF_POL1) begin
         next_rdata = first_polarity_control & `PSCOC_MASK_POL1;
      end else if (paddr == `PSCOC_OFF_CLK2) begin
         next_rdata = second_clock_select & `PSCOC_MASK_CLK;
      end else if (paddr == `PSCOC_OFF_OEN2) begin
         next_rdata = second_output_enables & `PSCOC_MASK_OEN2;
      end else if (paddr == `PSCOC_OFF_POL2) begin
         next_rdata = second_polarity_control & `PSCOC_MASK_POL2;
      end else begin
         next_err = 1'b1;
      end
   end

   // read data and error are captured in setup so they come from flops in access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup_phase) begin
         prdata <= {24'h000000, next_rdata};
         pslverr <= next_err;
      end
   end

   // unimplemented bits are never stored, so they cannot leak into the logic
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_period_sync_select <= `PSCOC_RST_REG;
         second_period_sync_select <= `PSCOC_RST_REG;
         first_clock_select <= `PSCOC_RST_REG;
         first_output_enables <= `PSCOC_RST_REG;
         first_polarity_control <= `PSCOC_RST_REG;
         second_clock_select <= `PSCOC_RST_REG;
         second_output_enables <= `PSCOC_RST_REG;
         second_polarity_control <= `PSCOC_RST_REG;
      end else if (write_strobe) begin
         if (paddr == `PSCOC_OFF_SYNC1) begin
            first_period_sync_select <= pwdata[7:0] & `PSCOC_MASK_SYNC;
         end else if (paddr == `PSCOC_OFF_SYNC2) begin
            second_period_sync_select <= pwdata[7:0] & `PSCOC_MASK_SYNC;
         end else if (paddr == `PSCOC_OFF_CLK1) begin
            first_clock_select <= pwdata[7:0] & `PSCOC_MASK_CLK;
         end else if (paddr == `PSCOC_OFF_OEN1) begin
            first_output_enables <= pwdata[7:0] & `PSCOC_MASK_OEN1;
         end else if (paddr == `PSCOC_OFF_POL1) begin
            first_polarity_control <= pwdata[7:0] & `PSCOC_MASK_POL1;
         end else if (paddr == `PSCOC_OFF_CLK2) begin
            second_clock_select <= pwdata[7:0] & `PSCOC_MASK_CLK;
         end else if (paddr == `PSCOC_OFF_OEN2) begin
            second_output_enables <= pwdata[7:0] & `PSCOC_MASK_OEN2;
         end else if (paddr == `PSCOC_OFF_POL2) begin
            second_polarity_control <= pwdata[7:0] & `PSCOC_MASK_POL2;
         end
      end
   end

   // prescaler ratios are applied by the timebase outside this slice
   assign first_clock_prescale_sel = first_clock_select[`PSCOC_CPRE_MSB:`PSCOC_CPRE_LSB];
   assign second_clock_prescale_sel = second_clock_select[`PSCOC_CPRE_MSB:`PSCOC_CPRE_LSB];

   pscoc_evt_sel #(
      .PEER_CODE(`PSCOC_SYNC1_PEER)
   ) u_first_sel (
      .pclk(pclk),
      .presetn(presetn),
      .sync_mode(first_period_sync_select[`PSCOC_SYNC_MSB:`PSCOC_SYNC_LSB]),
      .clock_source_sel(first_clock_select[`PSCOC_CSRC_MSB:`PSCOC_CSRC_LSB]),
      .input_polarity(first_polarity_control[`PSCOC_POLIN_BIT]),
      .own_period_event(first_period_event),
      .peer_period_event(second_period_event),
      .sys_clk_tick(sys_clk_tick),
      .pll_clk_tick(pll_clk_tick),
      .external_clock_pin(first_external_clock_pin),
      .external_event_input(first_external_event_input),
      .period_restart(first_period_restart),
      .clock_tick(first_clock_tick),
      .event_active(first_event_active)
   );

   pscoc_evt_sel #(
      .PEER_CODE(`PSCOC_SYNC2_PEER)
   ) u_second_sel (
      .pclk(pclk),
      .presetn(presetn),
      .sync_mode(second_period_sync_select[`PSCOC_SYNC_MSB:`PSCOC_SYNC_LSB]),
      .clock_source_sel(second_clock_select[`PSCOC_CSRC_MSB:`PSCOC_CSRC_LSB]),
      .input_polarity(second_polarity_control[`PSCOC_POLIN_BIT]),
      .own_period_event(second_period_event),
      .peer_period_event(first_period_event),
      .sys_clk_tick(sys_clk_tick),
      .pll_clk_tick(pll_clk_tick),
      .external_clock_pin(second_external_clock_pin),
      .external_event_input(second_external_event_input),
      .period_restart(second_period_restart),
      .clock_tick(second_clock_tick),
      .event_active(second_event_active)
   );

   pscoc_out_stage #(
      .W(`PSCOC_OUTS1)
   ) u_first_out (
      .pclk(pclk),
      .presetn(presetn),
      .wave(first_wave),
      .output_route_en(first_output_enables[5:0]),
      .output_polarity(first_polarity_control[5:0]),
      .port_out(first_port_out),
      .port_oe(first_port_oe),
      .pin_out(first_pin_out),
      .pin_oe(first_pin_oe)
   );

   // only outputs a and b exist on the second instance
   pscoc_out_stage #(
      .W(`PSCOC_OUTS2)
   ) u_second_out (
      .pclk(pclk),
      .presetn(presetn),
      .wave(second_wave),
      .output_route_en(second_output_enables[1:0]),
      .output_polarity(second_polarity_control[1:0]),
      .port_out(second_port_out),
      .port_oe(second_port_oe),
      .pin_out(second_pin_out),
      .pin_oe(second_pin_oe)
   );
endmodule // pscoc_top

`default_nettype wire
